// ==== rtl/line_error_pkg.sv ====
package line_error_pkg;

    localparam int ADDR_W  = 12;
    localparam int DATA_W  = 32;
    localparam int FLAG_W  = 6;
    localparam int EVENT_W = 5;
    localparam int COUNT_W = 16;
    localparam int TICK_W  = 28;

    localparam logic [ADDR_W-1:0] FLAGS_OFS      = 12'h000;
    localparam logic [ADDR_W-1:0] MASK_OFS       = 12'h004;
    localparam logic [ADDR_W-1:0] COUNT_LOW_OFS  = 12'h008;
    localparam logic [ADDR_W-1:0] COUNT_HIGH_OFS = 12'h00C;
    localparam logic [ADDR_W-1:0] CTRL_OFS       = 12'h010;
    localparam logic [ADDR_W-1:0] EDGE_OFS       = 12'h014;
    localparam logic [ADDR_W-1:0] LIVE_OFS       = 12'h018;

    localparam int BPV_A_BIT   = 5;
    localparam int BPV_B_BIT   = 4;
    localparam int EXZ_A_BIT   = 3;
    localparam int EXZ_B_BIT   = 2;
    localparam int PAT_ERR_BIT = 1;
    localparam int OVF_BIT     = 0;

    localparam int CTRL_UPDATE_BIT = 0;
    localparam int CTRL_MODE_BIT   = 1;

    localparam logic [FLAG_W-1:0]  FLAGS_RST = 6'h00;
    localparam logic [FLAG_W-1:0]  MASK_RST  = 6'h00;
    localparam logic [EVENT_W-1:0] EDGE_RST  = 5'h00;
    localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
    localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hFFFF;
    localparam logic [DATA_W-1:0]  RD_ZERO   = 32'h00000000;

    localparam int CLK_FREQ_KHZ  = 200000;
    localparam int ROUND_TIME_MS = 1000;
    localparam int ROUND_CYCLES  = CLK_FREQ_KHZ * ROUND_TIME_MS;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
        return addr == ofs;
    endfunction : reg_hit

endpackage : line_error_pkg

// ==== rtl/count_if.sv ====
`timescale 1ns/1ps
interface count_if;
    logic        err_pulse;
    logic        mode_auto;
    logic        manual_req;
    logic [15:0] visible;
    logic        overflow;

    modport owner   (output err_pulse, output mode_auto, output manual_req, input visible, input overflow);
    modport counter (input err_pulse, input mode_auto, input manual_req, output visible, output overflow);
endinterface : count_if

// ==== rtl/event_edge.sv ====
`timescale 1ns/1ps
module event_edge #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] level,
    input  wire logic [WIDTH-1:0] any_edge,
    output logic      [WIDTH-1:0] set
);

    logic [WIDTH-1:0] prev_ff;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= level;
        end
    end

    // Select zero reports rising edges only, select one reports both.
    for (genvar i = 0; i < WIDTH; i++) begin : g_edge
        assign set[i] = any_edge[i] ? (level[i] ^ prev_ff[i]) : (level[i] & ~prev_ff[i]);
    end

endmodule : event_edge

// ==== rtl/error_counter.sv ====
`timescale 1ns/1ps
module error_counter
    import line_error_pkg::*;
#(
    parameter int unsigned round_cycles = ROUND_CYCLES
) (
    input  wire logic ref_clk,
    input  wire logic reset,
    count_if.counter  cif
);

    logic [COUNT_W-1:0] accum_ff;
    logic [COUNT_W-1:0] visible_ff;
    logic               overflow_ff;
    logic [TICK_W-1:0]  tick_ff;
    logic               round_tick;
    logic               update;

    assign round_tick = (tick_ff == TICK_W'(round_cycles - 1));
    assign update     = cif.mode_auto ? round_tick : cif.manual_req;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tick_ff <= '0;
        end else if (!cif.mode_auto || round_tick) begin
            tick_ff <= '0;
        end else begin
            tick_ff <= tick_ff + 1'b1;
        end
    end

    // The count saturates so that an overflowed round never reads as a small number.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            accum_ff <= COUNT_RST;
        end else if (update) begin
            accum_ff <= {{(COUNT_W-1){1'b0}}, cif.err_pulse};
        end else if (cif.err_pulse && accum_ff != COUNT_MAX) begin
            accum_ff <= accum_ff + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            overflow_ff <= 1'b0;
        end else begin
            overflow_ff <= cif.err_pulse && !update && accum_ff == COUNT_MAX;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            visible_ff <= COUNT_RST;
        end else if (update) begin
            visible_ff <= accum_ff;
        end
    end

    assign cif.visible  = visible_ff;
    assign cif.overflow = overflow_ff;

    ////////////////////////////////////////////////////////////////////////////////////////////////////

    property p_manual_hold;
        @(posedge ref_clk) disable iff (reset)
        !cif.mode_auto && !cif.manual_req |=> $stable(visible_ff);
    endproperty
    a_manual_hold: assert property (p_manual_hold)
        else $error("Visible count changed without a manual request.");

    property p_manual_load;
        @(posedge ref_clk) disable iff (reset)
        !cif.mode_auto && cif.manual_req |=> visible_ff == $past(accum_ff);
    endproperty
    a_manual_load: assert property (p_manual_load)
        else $error("Manual request did not load the running count.");

    property p_overflow_pulse;
        @(posedge ref_clk) disable iff (reset)
        accum_ff == COUNT_MAX && cif.err_pulse && !update |=> overflow_ff && accum_ff == COUNT_MAX;
    endproperty
    a_overflow_pulse: assert property (p_overflow_pulse)
        else $error("Counter overflow not reported or count not saturated.");

endmodule : error_counter

// ==== rtl/line_error_irq_status_counter.sv ====
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
module line_error_irq_status_counter
    import line_error_pkg::*;
#(
    parameter int unsigned round_cycles = ROUND_CYCLES
) (
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irq,
    input  wire logic              bpv_a_level,
    input  wire logic              bpv_b_level,
    input  wire logic              exz_a_level,
    input  wire logic              exz_b_level,
    input  wire logic              pattern_error_level,
    input  wire logic              error_pulse
);

    ////////////////////////////////////////////////////////////////////////////////////////////////////

    logic [FLAG_W-1:0]  flags_ff;
    logic [FLAG_W-1:0]  nxt_flags;
    logic [FLAG_W-1:0]  mask_ff;
    logic [EVENT_W-1:0] edge_sel_ff;
    logic [EVENT_W-1:0] event_level;
    logic [EVENT_W-1:0] event_set;
    logic               mode_auto_ff;
    logic               manual_req_ff;
    logic [DATA_W-1:0]  prdata_ff;
    logic [DATA_W-1:0]  rd_word;
    logic               pready_ff;
    logic               pslverr_ff;
    logic               irq_ff;
    logic               mapped;
    logic               answer;
    logic               accept;
    logic               wr_en;

    count_if cif ();

    ////////////////////////////////////////////////////////////////////////////////////////////////////

    assign event_level = {bpv_a_level, bpv_b_level, exz_a_level, exz_b_level, pattern_error_level};

    event_edge #(
        .WIDTH    (EVENT_W)
    ) u_edges (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .level    (event_level),
        .any_edge (edge_sel_ff),
        .set      (event_set)
    );

    assign cif.err_pulse  = error_pulse;
    assign cif.mode_auto  = mode_auto_ff;
    assign cif.manual_req = manual_req_ff;

    error_counter #(
        .round_cycles (round_cycles)
    ) u_counter (
        .ref_clk      (ref_clk),
        .reset        (reset),
        .cif          (cif.counter)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////////

    // Every access takes one wait cycle; data and error are registered with pready.
    assign mapped = reg_hit(paddr, FLAGS_OFS) || reg_hit(paddr, MASK_OFS)
                 || reg_hit(paddr, COUNT_LOW_OFS) || reg_hit(paddr, COUNT_HIGH_OFS)
                 || reg_hit(paddr, CTRL_OFS) || reg_hit(paddr, EDGE_OFS) || reg_hit(paddr, LIVE_OFS);
    assign answer = psel && penable && !pready_ff;
    assign accept = psel && penable && pready_ff;
    assign wr_en  = accept && pwrite && !pslverr_ff;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= answer;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pslverr_ff <= 1'b0;
        end else begin
            pslverr_ff <= answer && !mapped;
        end
    end

    always_comb begin
        rd_word = RD_ZERO;
        if (reg_hit(paddr, FLAGS_OFS)) begin
            rd_word[FLAG_W-1:0] = flags_ff;
        end else if (reg_hit(paddr, MASK_OFS)) begin
            rd_word[FLAG_W-1:0] = mask_ff;
        end else if (reg_hit(paddr, COUNT_LOW_OFS)) begin
            rd_word[7:0] = cif.visible[7:0];
        end else if (reg_hit(paddr, COUNT_HIGH_OFS)) begin
            rd_word[7:0] = cif.visible[15:8];
        end else if (reg_hit(paddr, CTRL_OFS)) begin
            rd_word[CTRL_MODE_BIT] = mode_auto_ff;
        end else if (reg_hit(paddr, EDGE_OFS)) begin
            rd_word[EVENT_W-1:0] = edge_sel_ff;
        end else if (reg_hit(paddr, LIVE_OFS)) begin
            rd_word[EVENT_W-1:0] = event_level;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            prdata_ff <= RD_ZERO;
        end else if (answer && !pwrite) begin
            prdata_ff <= rd_word;
        end else if (accept) begin
            prdata_ff <= RD_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////////

    // A clear and a new event in the same cycle leave the flag set.
    always_comb begin
        nxt_flags = flags_ff;
        if (wr_en && reg_hit(paddr, FLAGS_OFS)) begin
            nxt_flags = flags_ff & ~pwdata[FLAG_W-1:0];
        end
        nxt_flags[BPV_A_BIT]   = nxt_flags[BPV_A_BIT] | event_set[BPV_A_BIT-1];
        nxt_flags[BPV_B_BIT]   = nxt_flags[BPV_B_BIT] | event_set[BPV_B_BIT-1];
        nxt_flags[EXZ_A_BIT]   = nxt_flags[EXZ_A_BIT] | event_set[EXZ_A_BIT-1];
        nxt_flags[EXZ_B_BIT]   = nxt_flags[EXZ_B_BIT] | event_set[EXZ_B_BIT-1];
        nxt_flags[PAT_ERR_BIT] = nxt_flags[PAT_ERR_BIT] | event_set[PAT_ERR_BIT-1];
        nxt_flags[OVF_BIT]     = nxt_flags[OVF_BIT] | cif.overflow;
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            flags_ff <= FLAGS_RST;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mask_ff <= MASK_RST;
        end else if (wr_en && reg_hit(paddr, MASK_OFS)) begin
            mask_ff <= pwdata[FLAG_W-1:0];
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            edge_sel_ff <= EDGE_RST;
        end else if (wr_en && reg_hit(paddr, EDGE_OFS)) begin
            edge_sel_ff <= pwdata[EVENT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mode_auto_ff <= 1'b0;
        end else if (wr_en && reg_hit(paddr, CTRL_OFS)) begin
            mode_auto_ff <= pwdata[CTRL_MODE_BIT];
        end
    end

    // The update bit is a self-clearing strobe; it only matters in manual mode.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            manual_req_ff <= 1'b0;
        end else begin
            manual_req_ff <= wr_en && reg_hit(paddr, CTRL_OFS) && pwdata[CTRL_UPDATE_BIT];
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(flags_ff & mask_ff);
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq     = irq_ff;

    ////////////////////////////////////////////////////////////////////////////////////////////////////

    property p_bpv_a_set;
        @(posedge ref_clk) disable iff (reset)
        $rose(bpv_a_level) |=> flags_ff[BPV_A_BIT] ##1 (flags_ff[BPV_A_BIT] || $past(wr_en));
    endproperty
    a_bpv_a_set: assert property (p_bpv_a_set)
        else $error("Bipolar violation A edge did not set its flag.");

    property p_w1c_clear;
        @(posedge ref_clk) disable iff (reset)
        wr_en && reg_hit(paddr, FLAGS_OFS) && !(|event_set) && !cif.overflow
            |=> (flags_ff & FLAG_W'($past(pwdata))) == FLAGS_RST;
    endproperty
    a_w1c_clear: assert property (p_w1c_clear)
        else $error("Writing one did not clear an interrupt flag.");

    property p_w0_keep;
        @(posedge ref_clk) disable iff (reset)
        wr_en && reg_hit(paddr, FLAGS_OFS) && pwdata[FLAG_W-1:0] == FLAGS_RST
            |=> (flags_ff & $past(flags_ff)) == $past(flags_ff);
    endproperty
    a_w0_keep: assert property (p_w0_keep)
        else $error("Writing zero changed an interrupt flag.");

    property p_bpv_b_set;
        @(posedge ref_clk) disable iff (reset)
        $rose(bpv_b_level) |=> flags_ff[BPV_B_BIT];
    endproperty
    a_bpv_b_set: assert property (p_bpv_b_set)
        else $error("Bipolar violation B edge did not set its flag.");

    property p_exz_a_set;
        @(posedge ref_clk) disable iff (reset)
        $rose(exz_a_level) |=> flags_ff[EXZ_A_BIT];
    endproperty
    a_exz_a_set: assert property (p_exz_a_set)
        else $error("Excess zeros A edge did not set its flag.");

    property p_exz_b_fall;
        @(posedge ref_clk) disable iff (reset)
        $fell(exz_b_level) && edge_sel_ff[EXZ_B_BIT-1] |=> flags_ff[EXZ_B_BIT];
    endproperty
    a_exz_b_fall: assert property (p_exz_b_fall)
        else $error("Excess zeros B fall with any-edge select did not set its flag.");

    property p_pattern_set;
        @(posedge ref_clk) disable iff (reset)
        $rose(pattern_error_level) |=> flags_ff[PAT_ERR_BIT];
    endproperty
    a_pattern_set: assert property (p_pattern_set)
        else $error("Pattern checker error did not set its flag.");

    property p_overflow_flag;
        @(posedge ref_clk) disable iff (reset)
        cif.overflow |=> flags_ff[OVF_BIT];
    endproperty
    a_overflow_flag: assert property (p_overflow_flag)
        else $error("Counter overflow did not set its flag.");

    property p_count_low_read;
        @(posedge ref_clk) disable iff (reset)
        answer && !pwrite && reg_hit(paddr, COUNT_LOW_OFS)
            |=> pready_ff && prdata_ff == {24'h000000, 8'($past(cif.visible))};
    endproperty
    a_count_low_read: assert property (p_count_low_read)
        else $error("Low count byte read returned the wrong value.");

    property p_rise_only;
        @(posedge ref_clk) disable iff (reset)
        $fell(exz_a_level) && !edge_sel_ff[EXZ_A_BIT-1] && !flags_ff[EXZ_A_BIT] |=> !flags_ff[EXZ_A_BIT];
    endproperty
    a_rise_only: assert property (p_rise_only)
        else $error("Falling edge set a flag while rising-only was selected.");

    property p_irq_level;
        @(posedge ref_clk) disable iff (reset)
        (|(flags_ff & mask_ff)) [*2] |-> irq_ff;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("Interrupt low while an enabled flag is set.");

    property p_irq_release;
        @(posedge ref_clk) disable iff (reset)
        !(|(flags_ff & mask_ff)) [*2] |-> !irq_ff;
    endproperty
    a_irq_release: assert property (p_irq_release)
        else $error("Interrupt high with no enabled flag set.");

    property p_exz_b_set;
        @(posedge ref_clk) disable iff (reset)
        $rose(exz_b_level) |=> flags_ff[EXZ_B_BIT];
    endproperty
    a_exz_b_set: assert property (p_exz_b_set)
        else $error("Excess zeros B edge did not set its flag.");

    property p_pattern_fall;
        @(posedge ref_clk) disable iff (reset)
        $fell(pattern_error_level) && edge_sel_ff[PAT_ERR_BIT-1] |=> flags_ff[PAT_ERR_BIT];
    endproperty
    a_pattern_fall: assert property (p_pattern_fall)
        else $error("Pattern checker fall with any-edge select did not set its flag.");

    property p_flag_hold;
        @(posedge ref_clk) disable iff (reset)
        !(wr_en && reg_hit(paddr, FLAGS_OFS)) |=> (flags_ff & $past(flags_ff)) == $past(flags_ff);
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("An interrupt flag cleared without a write of one.");

    property p_count_high_read;
        @(posedge ref_clk) disable iff (reset)
        answer && !pwrite && reg_hit(paddr, COUNT_HIGH_OFS)
            |=> pready_ff && prdata_ff == {24'h000000, 8'($past(cif.visible) >> 8)};
    endproperty
    a_count_high_read: assert property (p_count_high_read)
        else $error("High count byte read returned the wrong value.");

    property p_mode_write;
        @(posedge ref_clk) disable iff (reset)
        wr_en && reg_hit(paddr, CTRL_OFS) |=> mode_auto_ff == 1'($past(pwdata) >> CTRL_MODE_BIT);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("Counter mode bit did not follow the control write.");

    property p_irq_on;
        @(posedge ref_clk) disable iff (reset)
        (|(flags_ff & mask_ff)) |=> irq_ff;
    endproperty
    a_irq_on: assert property (p_irq_on)
        else $error("Interrupt did not rise one cycle after an enabled flag.");

    property p_irq_off;
        @(posedge ref_clk) disable iff (reset)
        !(|(flags_ff & mask_ff)) |=> !irq_ff;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("Interrupt did not fall one cycle after the last enabled flag.");

endmodule : line_error_irq_status_counter

// ==== sim/test_line_error_irq_status_counter.sv ====
`timescale 1ns/1ps
module test_line_error_irq_status_counter
    import line_error_pkg::*;
;

    localparam int RC = 64;

    logic              ref_clk;
    logic              reset;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              irq;
    logic [4:0]        lv;
    logic              error_pulse;
    logic [DATA_W-1:0] rq;
    logic              rerr;
    int                err_count;
    int                compares;
    int                flags_m;
    int                mask_m;
    int                edge_m;
    int                acc_m;
    int                vis_m;
    logic [ADDR_W-1:0] regs [7];

    ////////////////////////////////////////////////////////////////////////////////
    line_error_irq_status_counter #(.round_cycles(RC)) DUT (
        .ref_clk            (ref_clk),
        .reset              (reset),
        .psel               (psel),
        .penable            (penable),
        .pwrite             (pwrite),
        .paddr              (paddr),
        .pwdata             (pwdata),
        .prdata             (prdata),
        .pready             (pready),
        .pslverr            (pslverr),
        .irq                (irq),
        .bpv_a_level        (lv[4]),
        .bpv_b_level        (lv[3]),
        .exz_a_level        (lv[2]),
        .exz_b_level        (lv[1]),
        .pattern_error_level(lv[0]),
        .error_pulse        (error_pulse)
    );

    always #2.5 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
            err_count++;
        end
    endtask : check

    // One APB transfer; it returns one edge after completion with the bus idle.
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 50) begin
            $display("MISMATCH %0t no ready from slave", $time);
            err_count++;
        end
        rq = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    task automatic wr(input logic [ADDR_W-1:0] a, input int d);
        apb(1'b1, a, DATA_W'(d));
        check(DATA_W'(rerr), 32'h0, "write error response");
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input int exp);
        apb(1'b0, a, 32'h0);
        check(rq, DATA_W'(exp), "read data");
        check(DATA_W'(rerr), 32'h0, "read error response");
    endtask : rd

    task automatic chk_flags;
        rd(FLAGS_OFS, flags_m);
        check(DATA_W'(irq), DATA_W'((flags_m & mask_m) != 0), "interrupt level");
    endtask : chk_flags

    task automatic clr(input int b);
        wr(FLAGS_OFS, 1 << b);
        flags_m = flags_m & ~(1 << b);
    endtask : clr

    // Moves one event level; the model sets the flag on a rising edge or on any edge if selected.
    task automatic ev(input int e, input logic v);
        lv[e] <= v;
        if (v || edge_m[e]) begin
            flags_m = flags_m | (1 << (e + 1));
        end
        repeat (4) @(posedge ref_clk);
        chk_flags();
    endtask : ev

    task automatic pulses(input int n);
        logic b;
        for (int k = 0; k < n; k++) begin
            b = 1'($urandom % 2);
            error_pulse <= b;
            acc_m += int'(b);
            @(posedge ref_clk);
        end
        error_pulse <= 1'b0;
        @(posedge ref_clk);
    endtask : pulses

    task automatic summarize;
        if (err_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        lv = '0;
        error_pulse = 1'b0;
        err_count = 0;
        compares = 0;
        flags_m = 0;
        mask_m = 0;
        edge_m = 0;
        acc_m = 0;
        vis_m = 0;
        regs = '{FLAGS_OFS, MASK_OFS, COUNT_LOW_OFS, COUNT_HIGH_OFS, CTRL_OFS, EDGE_OFS, LIVE_OFS};
        void'($urandom(33263));
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        foreach (regs[i]) begin
            rd(regs[i], 0);
        end
        check(DATA_W'(irq), 32'h0, "interrupt after reset");
        apb(1'b0, 12'h01C, 32'h0);
        check(rq, 32'h0, "unmapped read data");
        check(DATA_W'(rerr), 32'h1, "unmapped read error");
        apb(1'b1, 12'h01C, 32'hFFFFFFFF);
        check(DATA_W'(rerr), 32'h1, "unmapped write error");
        for (int e = 0; e < EVENT_W; e++) begin
            mask_m = int'($urandom % 64) | (1 << (e + 1));
            wr(MASK_OFS, mask_m);
            rd(MASK_OFS, mask_m);
            edge_m = 0;
            wr(EDGE_OFS, 0);
            ev(e, 1'b1);
            wr(FLAGS_OFS, 32'hFFFFFFC0);
            chk_flags();
            mask_m = mask_m & ~(1 << (e + 1));
            wr(MASK_OFS, mask_m);
            chk_flags();
            clr(e + 1);
            chk_flags();
            ev(e, 1'b0);
            edge_m = 1 << e;
            wr(EDGE_OFS, edge_m);
            rd(EDGE_OFS, edge_m);
            ev(e, 1'b1);
            clr(e + 1);
            ev(e, 1'b0);
            clr(e + 1);
            chk_flags();
        end
        for (int r = 0; r < 2; r++) begin
            pulses(int'($urandom % 700));
            wr(CTRL_OFS, 1);
            vis_m = acc_m;
            acc_m = 0;
            rd(COUNT_LOW_OFS, vis_m & 255);
            rd(COUNT_HIGH_OFS, vis_m >> 8);
            rd(CTRL_OFS, 0);
        end
        wr(COUNT_LOW_OFS, 32'hFF);
        rd(COUNT_LOW_OFS, vis_m & 255);
        wr(CTRL_OFS, 2);
        rd(CTRL_OFS, 2);
        error_pulse <= 1'b1;
        repeat (3 * RC) @(posedge ref_clk);
        rd(COUNT_LOW_OFS, RC);
        rd(COUNT_HIGH_OFS, 0);
        error_pulse <= 1'b0;
        wr(CTRL_OFS, 0);
        wr(CTRL_OFS, 1);
        mask_m = 1;
        wr(MASK_OFS, mask_m);
        error_pulse <= 1'b1;
        repeat (65540) @(posedge ref_clk);
        error_pulse <= 1'b0;
        @(posedge ref_clk);
        flags_m = flags_m | 1;
        chk_flags();
        wr(CTRL_OFS, 1);
        rd(COUNT_LOW_OFS, 255);
        rd(COUNT_HIGH_OFS, 255);
        clr(0);
        chk_flags();
        summarize();
    end

    initial begin
        repeat (90000) @(posedge ref_clk);
        $display("MISMATCH %0t watchdog expired", $time);
        err_count++;
        summarize();
    end

endmodule : test_line_error_irq_status_counter
